//--- axis_parallel_command_port.sv
// parallel command port of the axis controller
`timescale 1ns/100ps
module axis_parallel_command_port #(
  parameter int PULSE_CYC = axis_port_pkg::PULSE_CYC,
  parameter int MEMKEY_CYC = axis_port_pkg::MEMKEY_CYC,
  parameter int BLINK_CYC = axis_port_pkg::BLINK_CYC
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [8:0] value_in,
  input wire logic [2:0] command_code_field_in,
  input wire logic axis_start_in,
  input wire logic strobe_in,
  input wire logic remote_in,
  input wire logic axis_moving_in,
  input wire logic cycle_change_in,
  input wire logic unit_error_in,
  input wire logic error_ack_in,
  input wire logic mem_key_in,
  input wire logic mem_exit_in,
  output logic error_out,
  output logic program_active_out,
  output logic start_request_out,
  output logic reference_start_out,
  output logic [8:0] upper_pos_out,
  output logic [8:0] lower_pos_out,
  output logic [8:0] speed_out,
  output logic [8:0] speed2_out,
  output logic [8:0] dwell_out,
  output logic [7:0] next_prog_out,
  output logic [7:0] program_number_out,
  output logic [2:0] operating_mode_param_out,
  output logic [1:0] error_output_style_param_out,
  output logic [7:0] program_display_out,
  output logic third_indicator_out,
  output logic mismatch_out
);
  if (PULSE_CYC < 1 || MEMKEY_CYC < 1 || BLINK_CYC < 1) begin : g_bad_timing
    $error("timing counts must be at least one");
  end

  // ------------------------------------------------------------
  // start-up sequencer and timers
  // ------------------------------------------------------------
  axis_port_pkg::state_t st_q;
  logic [31:0] pulse_q;
  logic [31:0] hold_q;
  logic [31:0] blink_q;
  logic blink_en;
  logic load_def;

  assign blink_en = (blink_q == 32'h0);
  assign load_def = (st_q == axis_port_pkg::ST_HOLD) && mem_key_in &&
    (hold_q == 32'(MEMKEY_CYC - 1));

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_q <= axis_port_pkg::ST_CHECK;
      hold_q <= 32'h0;
    end else begin
      case (st_q)
        axis_port_pkg::ST_CHECK: begin
          st_q <= mem_key_in ? axis_port_pkg::ST_HOLD : axis_port_pkg::ST_RUN;
        end
        axis_port_pkg::ST_HOLD: begin
          hold_q <= hold_q + 32'h1;
          if (!mem_key_in) begin
            st_q <= axis_port_pkg::ST_RUN;
          end else if (load_def) begin
            st_q <= axis_port_pkg::ST_MEM;
          end
        end
        axis_port_pkg::ST_MEM: begin
          if (mem_exit_in) begin
            st_q <= axis_port_pkg::ST_RUN;
          end
        end
        axis_port_pkg::ST_RUN: st_q <= axis_port_pkg::ST_RUN;
        default: st_q <= axis_port_pkg::ST_CHECK;
      endcase
    end
  end

  // power-on error pulse; reset stands in for power-up
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pulse_q <= 32'(PULSE_CYC);
    end else if (pulse_q != 32'h0) begin
      pulse_q <= pulse_q - 32'h1;
    end
  end

  // blink divider: one-cycle enable each half period
  always_ff @(posedge clk_in) begin
    if (reset_in || blink_en) begin
      blink_q <= 32'(BLINK_CYC - 1);
    end else begin
      blink_q <= blink_q - 32'h1;
    end
  end

  // ------------------------------------------------------------
  // strobe edge and triple sampling
  // ------------------------------------------------------------
  logic strobe_q;
  logic [1:0] samp_q;
  logic [11:0] cap_q;
  logic bad_q;
  logic fall;
  logic [11:0] bus;
  logic cmp_bad;
  logic done;

  assign bus = {command_code_field_in, value_in};
  assign fall = strobe_q && !strobe_in;
  assign cmp_bad = (bus != cap_q);
  assign done = (samp_q == 2'h2);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      strobe_q <= 1'b1;
      samp_q <= 2'h0;
      cap_q <= 12'h000;
      bad_q <= 1'b0;
    end else begin
      strobe_q <= strobe_in;
      if (fall && samp_q == 2'h0) begin
        cap_q <= bus;
        samp_q <= 2'h1;
        bad_q <= 1'b0;
      end else if (samp_q != 2'h0) begin
        bad_q <= bad_q | cmp_bad;
        samp_q <= done ? 2'h0 : samp_q + 2'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // decode and gating
  // ------------------------------------------------------------
  logic [2:0] code;
  logic [8:0] val;
  logic seq_mode;
  logic accept;
  logic in_range;
  logic mode_ok;
  logic commit;

  assign code = cap_q[11:9];
  assign val = cap_q[8:0];
  assign seq_mode = (operating_mode_param_out == axis_port_pkg::MODE_SEQ) ||
    (operating_mode_param_out == axis_port_pkg::MODE_CLEAN);

  always_comb begin
    in_range = 1'b1;
    mode_ok = 1'b1;
    case (code)
      axis_port_pkg::CMD_UPPER,
      axis_port_pkg::CMD_LOWER: in_range = (val <= axis_port_pkg::POS_MAX);
      axis_port_pkg::CMD_SPEED: begin
        in_range = (val >= axis_port_pkg::SPD_MIN) && (val <= axis_port_pkg::SPD_MAX);
      end
      axis_port_pkg::CMD_SPEED2: begin
        in_range = (val >= axis_port_pkg::SPD_MIN) && (val <= axis_port_pkg::SPD_MAX);
        mode_ok = !seq_mode;
      end
      axis_port_pkg::CMD_DWELL: begin
        in_range = (val <= axis_port_pkg::DWELL_MAX);
        mode_ok = seq_mode;
      end
      axis_port_pkg::CMD_NEXT: begin
        in_range = (val <= axis_port_pkg::BYTE_MAX);
        mode_ok = seq_mode;
      end
      axis_port_pkg::CMD_PROG: begin
        in_range = (val >= axis_port_pkg::PROG_MIN) && (val <= axis_port_pkg::BYTE_MAX);
      end
      axis_port_pkg::CMD_REF: in_range = (val <= axis_port_pkg::REF_MAX);
      default: in_range = 1'b0;
    endcase
  end

  // sequence modes refuse edits while travelling
  assign accept = !(seq_mode && axis_moving_in);
  assign commit = done && !bad_q && !cmp_bad && remote_in &&
    (st_q == axis_port_pkg::ST_RUN) && in_range && mode_ok && accept;

  // ------------------------------------------------------------
  // presets: positions and speeds staged, then applied at standstill or cycle change; dwell, next and program direct
  // ------------------------------------------------------------
  logic [8:0] up_pre_q;
  logic [8:0] lo_pre_q;
  logic [8:0] sp_pre_q;
  logic [8:0] sp2_pre_q;
  logic apply;

  // positions and speeds change only between strokes
  assign apply = !axis_moving_in || cycle_change_in;

  always_ff @(posedge clk_in) begin
    if (reset_in || load_def) begin
      up_pre_q <= axis_port_pkg::DEF_UPPER;
      lo_pre_q <= axis_port_pkg::DEF_LOWER;
      sp_pre_q <= axis_port_pkg::DEF_SPEED;
      sp2_pre_q <= axis_port_pkg::DEF_SPEED;
      dwell_out <= axis_port_pkg::DEF_DWELL;
      next_prog_out <= axis_port_pkg::DEF_NEXT;
      program_number_out <= axis_port_pkg::DEF_PROG;
    end else if (commit) begin
      case (code)
        axis_port_pkg::CMD_UPPER: up_pre_q <= val;
        axis_port_pkg::CMD_LOWER: lo_pre_q <= val;
        axis_port_pkg::CMD_SPEED: sp_pre_q <= val;
        axis_port_pkg::CMD_SPEED2: sp2_pre_q <= val;
        axis_port_pkg::CMD_DWELL: dwell_out <= val;
        axis_port_pkg::CMD_NEXT: next_prog_out <= val[7:0];
        axis_port_pkg::CMD_PROG: program_number_out <= val[7:0];
        default: dwell_out <= dwell_out;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || load_def) begin
      upper_pos_out <= axis_port_pkg::DEF_UPPER;
      lower_pos_out <= axis_port_pkg::DEF_LOWER;
      speed_out <= axis_port_pkg::DEF_SPEED;
      speed2_out <= axis_port_pkg::DEF_SPEED;
    end else if (apply) begin
      upper_pos_out <= up_pre_q;
      lower_pos_out <= lo_pre_q;
      speed_out <= sp_pre_q;
      speed2_out <= sp2_pre_q;
    end
  end

  // system parameters: only defaults here, keyboard setup lives elsewhere
  always_ff @(posedge clk_in) begin
    if (reset_in || load_def) begin
      operating_mode_param_out <= axis_port_pkg::DEF_MODE;
      error_output_style_param_out <= axis_port_pkg::DEF_STYLE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      reference_start_out <= 1'b0;
    end else begin
      reference_start_out <= commit && code == axis_port_pkg::CMD_REF &&
        val[0];
    end
  end

  // ------------------------------------------------------------
  // mismatch flag, status outputs, display
  // ------------------------------------------------------------
  logic mm_set;
  logic err_any;
  assign mm_set = done && (bad_q || cmp_bad);

  // set wins over acknowledge
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mismatch_out <= 1'b0;
    end else if (mm_set) begin
      mismatch_out <= 1'b1;
    end else if (error_ack_in) begin
      mismatch_out <= 1'b0;
    end
  end

  assign err_any = unit_error_in || mismatch_out || (pulse_q != 32'h0);
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      error_out <= 1'b0;
      program_active_out <= 1'b0;
      start_request_out <= 1'b0;
    end else begin
      // inverted style reads as a healthy-high line
      error_out <= (error_output_style_param_out == axis_port_pkg::STYLE_INV) ?
        !err_any : err_any;
      program_active_out <= axis_moving_in;
      start_request_out <= axis_start_in && remote_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      program_display_out <= axis_port_pkg::DEF_PROG;
      third_indicator_out <= 1'b0;
    end else if (st_q == axis_port_pkg::ST_MEM) begin
      program_display_out <= axis_port_pkg::MEM_SHOW;
      third_indicator_out <= third_indicator_out ^ blink_en;
    end else begin
      program_display_out <= mismatch_out ? axis_port_pkg::MISMATCH_SHOW :
        program_number_out;
      third_indicator_out <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_sample_three: assert property (@(posedge clk_in) disable iff (reset_in)
    fall && samp_q == 2'h0 |-> ##2 done)
    else $error("sampling did not finish after three samples");
  a_mismatch_flag: assert property (@(posedge clk_in) disable iff (reset_in)
    mm_set |=> mismatch_out ##1 program_display_out == axis_port_pkg::MISMATCH_SHOW)
    else $error("mismatch not flagged and shown");
  a_poweron_pulse: assert property (@(posedge clk_in) disable iff (reset_in)
    pulse_q != 32'h0 && error_output_style_param_out == axis_port_pkg::STYLE_LEVEL
    |=> error_out)
    else $error("error low during power-on pulse");
  a_error_style: assert property (@(posedge clk_in) disable iff (reset_in)
    unit_error_in |=>
    error_out == (error_output_style_param_out != axis_port_pkg::STYLE_INV))
    else $error("composite error not shown in its style");
  a_prog_active: assert property (@(posedge clk_in) disable iff (reset_in)
    !$past(reset_in) |-> program_active_out == $past(axis_moving_in))
    else $error("program active does not follow axis");
  a_seq_standstill: assert property (@(posedge clk_in) disable iff (reset_in)
    seq_mode && axis_moving_in && !load_def |=> $stable(dwell_out) && $stable(next_prog_out))
    else $error("edit taken while moving in sequence mode");
  a_mode_gate: assert property (@(posedge clk_in) disable iff (reset_in)
    done && !seq_mode && !load_def &&
    (code == axis_port_pkg::CMD_DWELL || code == axis_port_pkg::CMD_NEXT)
    |=> $stable(dwell_out) && $stable(next_prog_out))
    else $error("sequence-only code taken in pendulum mode");
  a_hold_moving: assert property (@(posedge clk_in) disable iff (reset_in)
    axis_moving_in && !cycle_change_in && !load_def |=> $stable(upper_pos_out))
    else $error("position changed mid stroke");
  a_ref_pulse: assert property (@(posedge clk_in) disable iff (reset_in)
    reference_start_out |=> !reference_start_out)
    else $error("reference start longer than one cycle");
  a_mem_show: assert property (@(posedge clk_in) disable iff (reset_in)
    load_def |=> ##1 program_display_out == axis_port_pkg::MEM_SHOW &&
    upper_pos_out == axis_port_pkg::DEF_UPPER)
    else $error("memory reset not shown or defaults not loaded");
endmodule : axis_parallel_command_port

//--- axis_parallel_command_port_bench.sv
// self-checking bench of the axis parallel command port
`timescale 1ns/100ps
module axis_parallel_command_port_bench;
  localparam int PULSE = 20;
  localparam int MEMK = 30;
  localparam int BLINK = 4;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic axis_moving_in = 1'b0;
  logic cycle_change_in = 1'b0;
  logic unit_error_in = 1'b0;
  logic error_ack_in = 1'b0;
  logic mem_key_in = 1'b0;
  logic mem_exit_in = 1'b0;
  logic [8:0] value_w;
  logic [2:0] code_w;
  logic strobe_w, remote_w, start_w;
  logic error_out, program_active_out, start_request_out, reference_start_out;
  logic [8:0] upper_pos_out, lower_pos_out, speed_out, speed2_out, dwell_out;
  logic [7:0] next_prog_out, program_number_out, program_display_out;
  logic [2:0] operating_mode_param_out;
  logic [1:0] error_output_style_param_out;
  logic third_indicator_out, mismatch_out;
  int n_errors = 0;
  int cmp_count = 0;
  int ref_cnt = 0;
  // ------------------------------------------------------------
  // clock, partner, design
  // ------------------------------------------------------------
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  plc_port_model plc (.clk_in(clk_in), .value_out(value_w), .command_code_field_out(code_w),
    .strobe_out(strobe_w), .remote_out(remote_w), .axis_start_out(start_w));
  axis_parallel_command_port #(.PULSE_CYC(PULSE), .MEMKEY_CYC(MEMK), .BLINK_CYC(BLINK)) dut (
    .clk_in(clk_in), .reset_in(reset_in), .value_in(value_w), .command_code_field_in(code_w),
    .axis_start_in(start_w), .strobe_in(strobe_w), .remote_in(remote_w),
    .axis_moving_in(axis_moving_in), .cycle_change_in(cycle_change_in),
    .unit_error_in(unit_error_in), .error_ack_in(error_ack_in), .mem_key_in(mem_key_in),
    .mem_exit_in(mem_exit_in), .error_out(error_out), .program_active_out(program_active_out),
    .start_request_out(start_request_out), .reference_start_out(reference_start_out),
    .upper_pos_out(upper_pos_out), .lower_pos_out(lower_pos_out), .speed_out(speed_out),
    .speed2_out(speed2_out), .dwell_out(dwell_out), .next_prog_out(next_prog_out),
    .program_number_out(program_number_out),
    .operating_mode_param_out(operating_mode_param_out),
    .error_output_style_param_out(error_output_style_param_out),
    .program_display_out(program_display_out), .third_indicator_out(third_indicator_out),
    .mismatch_out(mismatch_out));
  always @(posedge clk_in) begin
    if (reference_start_out === 1'b1) ref_cnt++;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [8:0] preset(input logic [2:0] c);
    case (c)
      3'h0: return upper_pos_out;
      3'h1: return lower_pos_out;
      3'h2: return speed_out;
      3'h3: return speed2_out;
      3'h4: return dwell_out;
      3'h5: return {1'b0, next_prog_out};
      default: return {1'b0, program_number_out};
    endcase
  endfunction : preset
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #800000;
    n_errors++;
    wrap_up();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // {code, value, expected preset}; mode stays pendulum, so 4 and 5 are gated
  logic [20:0] tbl [13] = '{
    {3'h0, 9'h064, 9'h064}, {3'h1, 9'h1F4, 9'h1F4}, {3'h2, 9'h008, 9'h008},
    {3'h3, 9'h03C, 9'h03C}, {3'h0, 9'h1F5, 9'h064}, {3'h2, 9'h007, 9'h008},
    {3'h2, 9'h03D, 9'h008}, {3'h4, 9'h005, 9'h000}, {3'h5, 9'h003, 9'h000},
    {3'h6, 9'h005, 9'h005}, {3'h6, 9'h000, 9'h005}, {3'h6, 9'h0FF, 9'h0FF},
    {3'h6, 9'h100, 9'h0FF}};
  initial begin
    int i;
    int tog;
    logic prev;
    cyc(4);
    reset_in = 1'b0;
    cyc(2);
    chk({8'h00, error_out}, 9'h001);
    chk(upper_pos_out, 9'h01E);
    chk(speed_out, 9'h014);
    chk(speed2_out, 9'h014);
    chk(lower_pos_out, 9'h000);
    chk({6'h00, operating_mode_param_out}, 9'h001);
    chk({7'h00, error_output_style_param_out}, 9'h000);
    for (i = 0; i < 100 && error_out !== 1'b0; i++) cyc(1);
    if (i == 100) begin
      n_errors++;
      wrap_up();
    end
    chk({8'h00, i >= PULSE - 4 && i <= PULSE}, 9'h001);
    for (int k = 0; k < 13; k++) begin
      plc.send(tbl[k][20:18], tbl[k][17:9], 1'b0);
      chk(preset(tbl[k][20:18]), tbl[k][8:0]);
    end
    chk({1'b0, program_display_out}, 9'h0FF);
    plc.send(3'h7, 9'h001, 1'b0);
    chk(9'(ref_cnt), 9'h001);
    plc.send(3'h7, 9'h000, 1'b0);
    chk(9'(ref_cnt), 9'h001);
    // edits while moving wait for the stroke reversal
    axis_moving_in = 1'b1;
    cyc(2);
    chk({8'h00, program_active_out}, 9'h001);
    plc.send(3'h0, 9'h050, 1'b0);
    chk(upper_pos_out, 9'h064);
    cycle_change_in = 1'b1;
    cyc(1);
    cycle_change_in = 1'b0;
    cyc(2);
    chk(upper_pos_out, 9'h050);
    axis_moving_in = 1'b0;
    cyc(2);
    chk({8'h00, program_active_out}, 9'h000);
    plc.set_ctl(1'b0, 1'b1);
    cyc(2);
    chk({8'h00, start_request_out}, 9'h000);
    plc.send(3'h0, 9'h0AA, 1'b0);
    chk(upper_pos_out, 9'h050);
    plc.set_ctl(1'b1, 1'b1);
    cyc(2);
    chk({8'h00, start_request_out}, 9'h001);
    plc.set_ctl(1'b1, 1'b0);
    unit_error_in = 1'b1;
    cyc(3);
    chk({8'h00, error_out}, 9'h001);
    unit_error_in = 1'b0;
    cyc(3);
    chk({8'h00, error_out}, 9'h000);
    plc.send(3'h0, 9'h033, 1'b1);
    chk({8'h00, mismatch_out}, 9'h001);
    chk({8'h00, error_out}, 9'h001);
    chk({1'b0, program_display_out}, 9'h01E);
    chk(upper_pos_out, 9'h050);
    error_ack_in = 1'b1;
    cyc(2);
    error_ack_in = 1'b0;
    cyc(2);
    chk({8'h00, mismatch_out}, 9'h000);
    chk({8'h00, error_out}, 9'h000);
    // memory reset: key held through a fresh power-on
    mem_key_in = 1'b1;
    reset_in = 1'b1;
    cyc(4);
    reset_in = 1'b0;
    cyc(MEMK + 6);
    chk({1'b0, program_display_out}, 9'h0FF);
    chk(upper_pos_out, 9'h01E);
    chk({1'b0, program_number_out}, 9'h001);
    tog = 0;
    prev = third_indicator_out;
    for (int k = 0; k < 4 * BLINK; k++) begin
      cyc(1);
      if (third_indicator_out !== prev) tog++;
      prev = third_indicator_out;
    end
    chk(9'(tog), 9'h004);
    mem_key_in = 1'b0;
    mem_exit_in = 1'b1;
    cyc(2);
    mem_exit_in = 1'b0;
    cyc(3);
    chk({1'b0, program_display_out}, 9'h001);
    wrap_up();
  end
endmodule : axis_parallel_command_port_bench

//--- axis_port_pkg.sv
// constants and types of the axis parallel command port
// Behaviour
// - fifteen inputs in, two status outputs out
// - inputs split: 12 data, 3 control
// - nine value bits plus 3-bit command code
// - device drives error and program-active flags
// - error pulses 0,1 s after power-on
// - error is composite, style set by parameter
// - program-active follows axis operation
// - codes 0..6 load presets within ranges
// - code 7 value 1 starts referencing
// - codes 3, 4, 5 gated by mode
// - sequence modes edit only at standstill
// - moving position and speed edits take effect at cycle change
// - memory reset loads all defaults
// - key held 10 s: show 255, blink
// - transfer starts on falling strobe edge
// - three samples; mismatch raises error, code
package axis_port_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int PULSE_MS = 100;
  localparam int MEMKEY_S = 10;
  localparam int BLINK_MS = 250;
  localparam int PULSE_CYC = CLK_HZ / 1000 * PULSE_MS;
  localparam int MEMKEY_CYC = CLK_HZ * MEMKEY_S;
  localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
  // ------------------------------------------------------------
  // command codes and modes
  // ------------------------------------------------------------
  localparam logic [2:0] CMD_UPPER = 3'h0;
  localparam logic [2:0] CMD_LOWER = 3'h1;
  localparam logic [2:0] CMD_SPEED = 3'h2;
  localparam logic [2:0] CMD_SPEED2 = 3'h3;
  localparam logic [2:0] CMD_DWELL = 3'h4;
  localparam logic [2:0] CMD_NEXT = 3'h5;
  localparam logic [2:0] CMD_PROG = 3'h6;
  localparam logic [2:0] CMD_REF = 3'h7;
  localparam logic [2:0] MODE_PEND = 3'h1;
  localparam logic [2:0] MODE_SEQ = 3'h2;
  localparam logic [2:0] MODE_SEMI = 3'h3;
  localparam logic [2:0] MODE_CLEAN = 3'h4;
  localparam logic [1:0] STYLE_LEVEL = 2'h0;
  localparam logic [1:0] STYLE_INV = 2'h2;
  // ------------------------------------------------------------
  // value ranges, counts of 0.01 steps
  // ------------------------------------------------------------
  localparam logic [8:0] POS_MAX = 9'h1F4;
  localparam logic [8:0] SPD_MIN = 9'h008;
  localparam logic [8:0] SPD_MAX = 9'h03C;
  localparam logic [8:0] DWELL_MAX = 9'h1F4;
  localparam logic [8:0] BYTE_MAX = 9'h0FF;
  localparam logic [8:0] PROG_MIN = 9'h001;
  localparam logic [8:0] REF_MAX = 9'h001;
  // ------------------------------------------------------------
  // defaults after memory reset
  // ------------------------------------------------------------
  localparam logic [8:0] DEF_UPPER = 9'h01E;
  localparam logic [8:0] DEF_LOWER = 9'h000;
  localparam logic [8:0] DEF_SPEED = 9'h014;
  localparam logic [8:0] DEF_DWELL = 9'h000;
  localparam logic [7:0] DEF_NEXT = 8'h00;
  localparam logic [7:0] DEF_PROG = 8'h01;
  localparam logic [2:0] DEF_MODE = 3'h1;
  localparam logic [1:0] DEF_STYLE = 2'h0;
  localparam logic [7:0] MEM_SHOW = 8'hFF;
  localparam logic [7:0] MISMATCH_SHOW = 8'h1E;
  // ------------------------------------------------------------
  // start-up sequencer
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_CHECK = 4'h1,
    ST_HOLD = 4'h2,
    ST_MEM = 4'h4,
    ST_RUN = 4'h8
  } state_t;
endpackage : axis_port_pkg

//--- plc_port_model.sv
// behavioural model of the controller that drives the parallel port
`timescale 1ns/100ps
module plc_port_model (
  input wire logic clk_in,
  output logic [8:0] value_out,
  output logic [2:0] command_code_field_out,
  output logic strobe_out,
  output logic remote_out,
  output logic axis_start_out
);
  // ------------------------------------------------------------
  // idle levels
  // ------------------------------------------------------------
  initial begin
    value_out = 9'h000;
    command_code_field_out = 3'h0;
    strobe_out = 1'b1;
    remote_out = 1'b1;
    axis_start_out = 1'b0;
  end
  // ------------------------------------------------------------
  // control lines
  // ------------------------------------------------------------
  task automatic set_ctl(input logic remote, input logic start);
    @(posedge clk_in);
    #1;
    remote_out = remote;
    axis_start_out = start;
  endtask : set_ctl
  // ------------------------------------------------------------
  // one transfer; glitch flips the value during sampling
  // ------------------------------------------------------------
  task automatic send(input logic [2:0] code, input logic [8:0] value, input logic glitch);
    @(posedge clk_in);
    #1;
    value_out = value;
    command_code_field_out = code;
    @(posedge clk_in);
    #1;
    strobe_out = 1'b0;
    @(posedge clk_in);
    #1;
    if (glitch) begin
      value_out = ~value;
    end
    repeat (2) @(posedge clk_in);
    #1;
    strobe_out = 1'b1;
    // released bus shows no stale value
    value_out = ~value_out;
    command_code_field_out = ~code;
    repeat (3) @(posedge clk_in);
    #1;
  endtask : send
endmodule : plc_port_model
